// File: design/lsdmc_core.sv
// Mode control of twelve low-side drivers with a sampled serial port
`timescale 1ns/10ps
`default_nettype none
module lsdmc_core #(
    parameter int NUM_CH = lsdmc_pkg::NUM_CH
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic vddOk,
    input wire logic vddaOk,
    input wire logic enable,
    input wire lsdmc_pkg::lsdmc_link_t link,
    input wire logic [NUM_CH-1:0] overload,
    output logic sdo,
    output logic sdoEn,
    output logic [NUM_CH-1:0] driveOn,
    output logic [NUM_CH-1:0] diagOn,
    output logic [NUM_CH-1:0] faultLatched,
    output logic transfer_error_flag,
    output logic frame_length_flag,
    output lsdmc_pkg::lsdmc_status_t status
);
    ////////////////////////////////////////////////////////////////////////
    // Two-stage input synchronisers
    logic [3:0] linkS1_q;
    logic [3:0] linkS2_q;
    logic [2:0] pwrS1_q;
    logic [2:0] pwrS2_q;
    logic [NUM_CH-1:0] overS1_q;
    logic [NUM_CH-1:0] overS2_q;
    logic sclkOld_q;
    lsdmc_pkg::lsdmc_link_t ls;
    assign ls = linkS2_q;
    // Overload comes from the analog detectors, so it is synced like a pin
    always_ff @(posedge clock)
    begin
        linkS1_q <= link;
        linkS2_q <= linkS1_q;
        pwrS1_q <= {vddOk, vddaOk, enable};
        pwrS2_q <= pwrS1_q;
        overS1_q <= overload;
        overS2_q <= overS1_q;
        sclkOld_q <= ls.sclk;
    end
    logic lockout;
    logic sleepMode;
    logic killAll;
    assign lockout = !(pwrS2_q[2] && pwrS2_q[1]);
    assign sleepMode = !pwrS2_q[0];
    assign killAll = srst || lockout || sleepMode;
    logic sclkFall;
    logic sclkRise;
    logic anySel;
    assign sclkFall = sclkOld_q && !ls.sclk;
    assign sclkRise = !sclkOld_q && ls.sclk;
    assign anySel = !(ls.selLowN && ls.selHighN);

    ////////////////////////////////////////////////////////////////////////
    // Frame shifter
    logic [31:0] shIn_q, shIn_d;
    logic [31:0] shOut_q, shOut_d;
    logic [5:0] cnt_q, cnt_d;
    logic sel_q;
    logic [1:0] mode_q, mode_d;
    logic frameEnd;
    logic sdo_q, sdo_d;
    logic [31:0] in_q, in_d;
    logic ter_q, ter_d;
    logic frame_length_flag_q, frame_length_flag_d;
    logic [NUM_CH-1:0] on_q, on_d, diag_q, diag_d, flt_q, flt_d;
    logic powerUp_q, powerUp_d;

    assign frameEnd = sel_q && !anySel;

    function automatic logic [1:0] chCmd(input logic [31:0] w, input int i);
        chCmd = w[2*i +: 2];
    endfunction : chCmd

    always_comb
    begin
        shIn_d = shIn_q;
        shOut_d = shOut_q;
        cnt_d = cnt_q;
        mode_d = mode_q;
        sdo_d = sdo_q;
        if (anySel && !sel_q)
        begin
            cnt_d = lsdmc_pkg::CNT_ZERO;
            mode_d = {!ls.selHighN, !ls.selLowN};
            shOut_d = {ter_q, 7'h00, flt_q, flt_q[NUM_CH-1:0]};
            sdo_d = ter_q;
        end
        else if (anySel)
        begin
            if (sclkFall)
            begin
                shIn_d = {shIn_q[30:0], ls.sdi};
                cnt_d = cnt_q + lsdmc_pkg::CNT_ONE;
            end
            if (sclkRise)
            begin
                sdo_d = shOut_q[31];
                shOut_d = {shOut_q[30:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decode, channel modes, faults
    logic okLen;
    logic [31:0] newIn;
    always_comb
    begin
        okLen = 1'b0;
        newIn = in_q;
        frame_length_flag_d = frame_length_flag_q;
        case (mode_q)
            2'h3:
            begin
                okLen = cnt_q == 6'(lsdmc_pkg::FULL_BITS);
                newIn = shIn_q;
            end
            2'h2:
            begin
                okLen = cnt_q == 6'(lsdmc_pkg::SHORT_BITS)
                    || cnt_q == 6'(lsdmc_pkg::EXT_BITS);
                frame_length_flag_d = cnt_q == 6'(lsdmc_pkg::EXT_BITS);
                newIn = frame_length_flag_d ? {in_q[31:24], shIn_q[23:0]}
                    : {shIn_q[15:0], in_q[15:0]};
            end
            default:
            begin
                okLen = cnt_q == 6'(lsdmc_pkg::SHORT_BITS);
                newIn = {in_q[31:16], shIn_q[15:0]};
            end
        endcase
        if (!frameEnd)
            frame_length_flag_d = frame_length_flag_q;
    end

    always_comb
    begin
        in_d = in_q;
        ter_d = ter_q;
        on_d = on_q;
        diag_d = diag_q;
        flt_d = flt_q | (overS2_q & on_q);
        powerUp_d = powerUp_q;
        if (frameEnd && cnt_q != lsdmc_pkg::CNT_ZERO)
        begin
            ter_d = !okLen;
            if (okLen)
            begin
                in_d = newIn;
                for (int i = 0; i < NUM_CH; i++)
                begin
                    case (chCmd(newIn, i))
                        lsdmc_pkg::CMD_OFF:
                        begin
                            on_d[i] = 1'b0;
                            diag_d[i] = !powerUp_q;
                        end
                        lsdmc_pkg::CMD_ON:
                        begin
                            on_d[i] = 1'b1;
                            diag_d[i] = 1'b0;
                        end
                        lsdmc_pkg::CMD_STANDBY:
                        begin
                            on_d[i] = 1'b0;
                            diag_d[i] = 1'b0;
                            // A fresh overload wins over the clear
                            flt_d = overS2_q & on_q;
                        end
                        default: ;
                    endcase
                end
                powerUp_d = 1'b0;
            end
        end
        on_d = on_d & ~flt_d;
    end

    always_ff @(posedge clock)
    begin
        if (killAll)
        begin
            sel_q <= 1'b0;
            cnt_q <= lsdmc_pkg::CNT_ZERO;
            mode_q <= 2'h0;
            shIn_q <= '0;
            shOut_q <= '0;
            sdo_q <= 1'b0;
            in_q <= lsdmc_pkg::IN_RESET;
            ter_q <= 1'b1;
            frame_length_flag_q <= 1'b0;
            on_q <= '0;
            diag_q <= '0;
            flt_q <= '0;
            powerUp_q <= 1'b1;
        end
        else
        begin
            sel_q <= anySel;
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            shIn_q <= shIn_d;
            shOut_q <= shOut_d;
            sdo_q <= sdo_d;
            in_q <= in_d;
            ter_q <= ter_d;
            frame_length_flag_q <= frame_length_flag_d;
            on_q <= on_d;
            diag_q <= diag_d;
            flt_q <= flt_d;
            powerUp_q <= powerUp_d;
        end
    end

    logic allOff;
    logic allStby;
    always_comb
    begin
        allOff = 1'b1;
        allStby = 1'b1;
        for (int i = 0; i < NUM_CH; i++)
        begin
            allOff = allOff && chCmd(in_q, i) == lsdmc_pkg::CMD_OFF;
            allStby = allStby && chCmd(in_q, i) == lsdmc_pkg::CMD_STANDBY;
        end
    end

    assign sdo = sdo_q;
    assign sdoEn = anySel && !killAll;
    assign driveOn = on_q;
    assign diagOn = diag_q;
    assign faultLatched = flt_q;
    assign transfer_error_flag = ter_q;
    assign frame_length_flag = frame_length_flag_q;
    assign status = {on_q, diag_q, allOff && !killAll, allStby && !killAll,
        lockout, sleepMode};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_lockout_outputs_off: assert property (@(posedge clock)
        lockout |=> driveOn == '0) else $error("Output on in lockout");
    a_sleep_clears_all: assert property (@(posedge clock)
        sleepMode |=> (driveOn == '0 && diagOn == '0 && transfer_error_flag))
        else $error("Sleep did not clear state");
    a_fault_forces_off: assert property (@(posedge clock)
        disable iff (srst)
        faultLatched[0] |-> !driveOn[0]) else $error("Faulted channel on");
    a_fault_stays_latched: assert property (@(posedge clock)
        disable iff (killAll)
        (faultLatched[0] && !frameEnd) |=> faultLatched[0])
        else $error("Fault latch lost");
    a_reset_diag_off: assert property (@(posedge clock)
        $fell(killAll) |-> diagOn == '0) else $error("Diag on after reset");
    a_standby_clears_faults: assert property (@(posedge clock)
        disable iff (killAll)
        (frameEnd && cnt_q != lsdmc_pkg::CNT_ZERO && okLen
        && chCmd(newIn, 0) == lsdmc_pkg::CMD_STANDBY
        && (overS2_q & on_q) == '0) |=> faultLatched == '0)
        else $error("Standby left a fault latched");
endmodule : lsdmc_core
`default_nettype wire

// File: design/lsdmc_pkg.sv
// Package with constants and types for the low-side driver mode control
package lsdmc_pkg;
    localparam int NUM_CH = 12;
    localparam int CMD_W = 2;
    localparam int FRAME_W = 32;
    localparam int SHORT_BITS = 16;
    localparam int EXT_BITS = 24;
    localparam int FULL_BITS = 32;
    localparam int CNT_W = 6;
    localparam logic [1:0] CMD_STANDBY = 2'h0;
    localparam logic [1:0] CMD_ON = 2'h2;
    localparam logic [1:0] CMD_OFF = 2'h3;
    localparam logic [31:0] IN_RESET = 32'hFFFFFFFF;
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [5:0] CNT_ONE = 6'h01;

    typedef struct packed {
        logic selLowN;
        logic selHighN;
        logic sclk;
        logic sdi;
    } lsdmc_link_t;

    typedef struct packed {
        logic [NUM_CH-1:0] outOn;
        logic [NUM_CH-1:0] diagEn;
        logic globalOff;
        logic globalStandby;
        logic supplyLockout;
        logic sleep;
    } lsdmc_status_t;
endpackage : lsdmc_pkg

// File: testbench/lsdmc_core_bench.sv
// Self-checking bench for the low-side driver mode control
`timescale 1ns/10ps
`default_nettype none
module lsdmc_core_bench;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic vddOk = 1'b1;
    logic vddaOk = 1'b1;
    logic enable = 1'b1;
    logic [11:0] overload = 12'h000;
    lsdmc_pkg::lsdmc_link_t link;
    lsdmc_pkg::lsdmc_status_t status;
    logic sdo, sdoEn, errFlag, lenFlag;
    logic [11:0] driveOn, diagOn, faultLatched;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    always #20 clock = ~clock;

    lsdmc_host u_host (.clock(clock), .sdo(sdo), .sdoEn(sdoEn),
        .link(link));
    lsdmc_core u_dut (.clock(clock), .srst(srst), .vddOk(vddOk),
        .vddaOk(vddaOk), .enable(enable), .link(link), .overload(overload),
        .sdo(sdo), .sdoEn(sdoEn), .driveOn(driveOn), .diagOn(diagOn),
        .faultLatched(faultLatched), .transfer_error_flag(errFlag),
        .frame_length_flag(lenFlag), .status(status));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        check_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    // Whole run needs about 3400 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(driveOn, 12'h000);
        check(diagOn, 12'h000);
        check(faultLatched, 12'h000);
        check({11'h000, errFlag}, 12'h001);
        u_host.frame(32'hFFAAAAAA, 32, 1'b0, 1'b0);
        check(driveOn, 12'hFFF);
        check({11'h000, u_host.rxWord[31]}, 12'h001);
        check({11'h000, u_host.rxEn}, 12'h001);
        check({11'h000, sdoEn}, 12'h000);
    endtask : t_reset

    task automatic t_fault;
        u_host.frame(32'h00EEEEEE, 24, 1'b1, 1'b0);
        check(driveOn, 12'h555);
        check(diagOn, 12'hAAA);
        check({11'h000, lenFlag}, 12'h001);
        overload = 12'h001;
        repeat (8) @(negedge clock);
        // Latch must hold after the overload goes away
        overload = 12'h000;
        repeat (8) @(negedge clock);
        check(driveOn, 12'h554);
        check(faultLatched, 12'h001);
        u_host.frame(32'h00000000, 16, 1'b0, 1'b1);
        check({11'h000, u_host.rxWord[15]}, 12'h000);
        check(faultLatched, 12'h000);
        check(driveOn, 12'h500);
        check(diagOn, 12'hA00);
        u_host.frame(32'hFFAAAAAA, 20, 1'b0, 1'b0);
        check({11'h000, errFlag}, 12'h001);
        check(driveOn, 12'h500);
    endtask : t_fault

    task automatic t_global;
        u_host.frame(32'hFFFFFFFF, 32, 1'b0, 1'b0);
        check({11'h000, u_host.rxWord[31]}, 12'h001);
        check(diagOn, 12'hFFF);
        check({11'h000, status.globalOff}, 12'h001);
        u_host.frame(32'h00000000, 32, 1'b0, 1'b0);
        check(diagOn | driveOn, 12'h000);
        check({11'h000, status.globalStandby}, 12'h001);
    endtask : t_global

    task automatic t_sleep;
        u_host.frame(32'hFFAAAAAA, 32, 1'b0, 1'b0);
        enable = 1'b0;
        u_host.frame(32'hFFAAAAAA, 32, 1'b0, 1'b0);
        check(driveOn, 12'h000);
        check({11'h000, status.sleep}, 12'h001);
        enable = 1'b1;
        repeat (8) @(negedge clock);
        check(diagOn | faultLatched, 12'h000);
        check({11'h000, status.globalOff}, 12'h001);
        check({11'h000, errFlag}, 12'h001);
    endtask : t_sleep

    task automatic t_lockout;
        for (int k = 0; k < 2; k++)
        begin
            u_host.frame(32'hFFAAAAAA, 32, 1'b0, 1'b0);
            vddOk = k[0];
            vddaOk = ~k[0];
            repeat (8) @(negedge clock);
            check(driveOn, 12'h000);
            check({11'h000, status.supplyLockout}, 12'h001);
            vddOk = 1'b1;
            vddaOk = 1'b1;
            repeat (8) @(negedge clock);
            check(diagOn | driveOn, 12'h000);
            check({11'h000, status.globalOff}, 12'h001);
            u_host.frame(32'hFFFFFFFF, 32, 1'b0, 1'b0);
            check(diagOn, 12'h000);
        end
    endtask : t_lockout

    initial
    begin
        repeat (16) @(negedge clock);
        srst = 1'b0;
        repeat (8) @(negedge clock);
        t_reset();
        t_fault();
        t_global();
        t_sleep();
        t_lockout();
        finish_test();
    end
endmodule : lsdmc_core_bench
`default_nettype wire

// File: testbench/lsdmc_host.sv
// Host serial master model driving the link pins
`timescale 1ns/10ps
`default_nettype none
module lsdmc_host (
    input wire logic clock,
    input wire logic sdo,
    input wire logic sdoEn,
    output var lsdmc_pkg::lsdmc_link_t link
);
    // Idle: selects pulled up, clock and data pulled down
    initial link = 4'hC;
    // Bits read back on each falling clock, newest in bit 0
    logic [31:0] rxWord = 32'h00000000;
    logic rxEn = 1'b0;

    task automatic frame(input logic [31:0] w, input int n, input logic lo,
        input logic hi);
        @(negedge clock);
        link.selLowN = lo;
        link.selHighN = hi;
        rxEn = 1'b1;
        repeat (4) @(negedge clock);
        for (int i = n - 1; i >= 0; i--)
        begin
            link.sdi = w[i];
            link.sclk = 1'b1;
            repeat (4) @(negedge clock);
            rxWord = {rxWord[30:0], sdo};
            rxEn = rxEn && sdoEn;
            link.sclk = 1'b0;
            repeat (4) @(negedge clock);
        end
        link = 4'hC;
        // Gap also covers the output update delay
        repeat (40) @(negedge clock);
    endtask : frame
endmodule : lsdmc_host
`default_nettype wire
